// file: pkg/pmcb_regs.svh
/*
  Command codes, reset values, field positions and timing counts of the
  manufacturer command bank. Assumes a 40 MHz system clock.
*/
// What this block does
// - Four shared fault pin response bytes, reset zero
// - Input enable pin OV and UV response bytes
// - Retry interval word, milliseconds, default 200
// - Restart delay postpones internal control active edge
// - Peak records of vout, vin and temperature
// - Per channel 10-bit trim DAC code word
// - Power good assertion delayed by millisecond word
// - Two watchdog interval words, default zero
// - Global page channel mask, default all enabled
// - Read returns present levels of selected pads
// - Bus address base byte, default 0x5c
// - Fixed maker identification word on read
// - Per channel factory configuration lot code byte
// - Off threshold is command voltage times coefficient
// - Send byte requests fault log store to nonvolatile
// - Fault log store acts like channel fault off
// - Linear eleven: 5-bit exponent, 11-bit mantissa
// - Linear sixteen: unsigned mantissa, exponent minus thirteen
// - Global page write hits every masked channel
`ifndef PMCB_REGS_SVH
`define PMCB_REGS_SVH

`define PMCB_CMD_FAULT_PIN0 8'hd5
`define PMCB_CMD_FAULT_PIN3 8'hd8
`define PMCB_CMD_IEN_OV 8'hd9
`define PMCB_CMD_IEN_UV 8'hda
`define PMCB_CMD_RETRY 8'hdb
`define PMCB_CMD_RESTART 8'hdc
`define PMCB_CMD_VOUT_PEAK 8'hdd
`define PMCB_CMD_VIN_PEAK 8'hde
`define PMCB_CMD_TEMP_PEAK 8'hdf
`define PMCB_CMD_TRIM_DAC 8'he0
`define PMCB_CMD_PG_DELAY 8'he1
`define PMCB_CMD_WD_FIRST 8'he2
`define PMCB_CMD_WD_INT 8'he3
`define PMCB_CMD_PAGE_MASK 8'he4
`define PMCB_CMD_PADS 8'he5
`define PMCB_CMD_ADDR_BASE 8'he6
`define PMCB_CMD_MAKER_ID 8'he7
`define PMCB_CMD_LOT_CODE 8'he8
`define PMCB_CMD_DISCH_COEFF 8'he9
`define PMCB_CMD_LOG_STORE 8'hea

`define PMCB_PAGE_GLOBAL 8'hff

`define PMCB_RST_FAULT_RESP 8'h00
`define PMCB_RST_IEN_RESP 8'h00
`define PMCB_RST_RETRY 16'hf320
`define PMCB_RST_RESTART 16'hfb20
`define PMCB_RST_PG_DELAY 16'heb20
`define PMCB_RST_WD 16'h8000
`define PMCB_RST_PAGE_MASK 8'hff
`define PMCB_RST_ADDR_BASE 8'h5c
`define PMCB_RST_DISCH_COEFF 16'hc200

`define PMCB_L11_EXP_MSB 15
`define PMCB_L11_EXP_LSB 11
`define PMCB_L11_MANT_MSB 10
`define PMCB_L16_EXP (-13)
`define PMCB_DAC_BITS 10

`define PMCB_CLK_PERIOD_NS 25
`define PMCB_MS_NS 1000000
`define PMCB_MS_CYCLES (`PMCB_MS_NS / `PMCB_CLK_PERIOD_NS)

`endif

// file: pkg/pmcb_pkg.sv
/*
  Types of the manufacturer command bank: the whole state record.
  Assumes eight channels and a 20-bit millisecond count range.
*/
`default_nettype none
package pmcb_pkg;

  typedef logic [19:0] pmcb_ms_t;

  typedef struct packed {
    logic [3:0][7:0] fault_resp;
    logic [7:0] ov_resp;
    logic [7:0] uv_resp;
    logic [15:0] retry;
    logic [15:0] restart;
    logic [15:0] pg_delay;
    logic [15:0] wd_first;
    logic [15:0] wd_int;
    logic [7:0] page_mask;
    logic [7:0] addr_base;
    logic [7:0][9:0] dac;
    logic [7:0][15:0] coeff;
    logic [7:0][15:0] thr;
    logic [7:0][15:0] vout_peak;
    logic [7:0] vout_seen;
    logic [15:0] vin_peak;
    logic vin_seen;
    logic [15:0] temp_peak;
    logic temp_seen;
    logic [15:0] rdata;
    logic rvalid;
    logic cml;
    logic log_store;
    logic fault_off;
    logic [15:0] ms_div;
    logic ms_tick;
    pmcb_ms_t restart_cnt;
    logic ctrl_int;
    pmcb_ms_t pg_cnt;
    logic pg_out;
    pmcb_ms_t retry_cnt;
    logic retry_pulse;
  } pmcb_state_t;

endpackage : pmcb_pkg
`default_nettype wire

// file: hdl/pmcb_bank.sv
/*
  Manufacturer command bank: decoded command port from the serial bus
  layer, settings, peak telemetry, delays and threshold computation.
  Assumes the bus layer hands over one decoded command per strobe and
  that measurement inputs are synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pmcb_regs.svh"
module pmcb_bank
  import pmcb_pkg::*;
#(
  parameter int MS_CYCLES = `PMCB_MS_CYCLES,
  parameter logic [15:0] MAKER_ID = 16'h0a5a  // Arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_send,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [7:0] page,
  input wire logic vout_meas_valid,
  input wire logic [2:0] vout_meas_ch,
  input wire logic [15:0] vout_meas,
  input wire logic vin_meas_valid,
  input wire logic [15:0] vin_meas,
  input wire logic temp_meas_valid,
  input wire logic [15:0] temp_meas,
  input wire logic [15:0] pad_in,
  input wire logic [7:0][7:0] nv_lot_code,
  input wire logic [7:0][15:0] vout_command,
  input wire logic control_pin_active,
  input wire logic power_good_raw,
  input wire logic retry_active,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic cml_fault,
  output logic fault_log_store,
  output logic fault_off_event,
  output logic [3:0][7:0] fault_pin_response,
  output logic [7:0] input_enable_ov_response,
  output logic [7:0] input_enable_uv_response,
  output logic [15:0] watchdog_first_interval,
  output logic [15:0] watchdog_interval,
  output logic [7:0] global_page_channel_mask,
  output logic [7:0] bus_address_base,
  output logic [7:0][9:0] trim_dac_code,
  output logic [7:0][15:0] discharge_threshold,
  output logic control_internal_active,
  output logic power_good_out,
  output logic retry_strobe
);

  // ==========================================================
  // Parameter checks
  // Divider is 16 bits; zero would wrap to a 65536-cycle tick
  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_ms_range
    $error("MS_CYCLES out of range");
  end

  // ==========================================================
  // Number format helpers
  // Linear eleven to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic signed [5:0] e;
    m = {{37{w[`PMCB_L11_MANT_MSB]}}, w[`PMCB_L11_MANT_MSB:0]};
    e = {w[`PMCB_L11_EXP_MSB], w[`PMCB_L11_EXP_MSB:`PMCB_L11_EXP_LSB]};
    // Six-bit exponent, so adding sixteen never wraps
    l11_fix = m <<< 6'(e + 6'sd16);
  endfunction : l11_fix

  // Whole milliseconds of a linear eleven word; negative reads as zero
  function automatic pmcb_ms_t l11_ms(input logic [15:0] w);
    logic signed [47:0] f;
    f = l11_fix(w) >>> 16;
    if (f < 0) begin
      l11_ms = '0;
    end else if (f > 48'sh0fffff) begin
      l11_ms = 20'hfffff;
    end else begin
      l11_ms = f[19:0];
    end
  endfunction : l11_ms

  // Linear sixteen command times linear eleven coefficient, result linear sixteen
  function automatic logic [15:0] disch_thr(input logic [15:0] v, input logic [15:0] c);
    logic signed [27:0] p;
    logic signed [47:0] x;
    logic signed [5:0] e;
    p = $signed({1'b0, v}) * $signed(c[`PMCB_L11_MANT_MSB:0]);
    e = {c[`PMCB_L11_EXP_MSB], c[`PMCB_L11_EXP_MSB:`PMCB_L11_EXP_LSB]};
    x = {{20{p[27]}}, p};
    if (e < 0) begin
      x = x >>> 6'(-e);
    end else begin
      x = x <<< e;
    end
    // Saturate instead of wrapping so a large coefficient never lowers the threshold
    if (x < 0) begin
      disch_thr = '0;
    end else if (x > 48'sh00ffff) begin
      disch_thr = 16'hffff;
    end else begin
      disch_thr = x[15:0];
    end
  endfunction : disch_thr

  // ==========================================================
  // State
  pmcb_state_t s_reg;
  pmcb_state_t s_next;

  logic page_ok;
  logic page_global;
  logic [2:0] pch;
  logic do_write;
  logic do_read;
  logic do_send;

  // Channel pages 0 to 7, or the global page
  assign page_ok = page < 8'h08;
  assign page_global = page == `PMCB_PAGE_GLOBAL;
  assign pch = page[2:0];
  assign do_write = cmd_valid && !cmd_read && !cmd_send;
  assign do_read = cmd_valid && cmd_read;
  assign do_send = cmd_valid && cmd_send;

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.cml = 1'b0;
    s_next.log_store = 1'b0;
    s_next.fault_off = 1'b0;
    s_next.retry_pulse = 1'b0;

    // Millisecond enable
    // Free running: a delay may fall one tick short
    s_next.ms_tick = 1'b0;
    if (s_reg.ms_div == 16'(MS_CYCLES - 1)) begin
      s_next.ms_div = '0;
      s_next.ms_tick = 1'b1;
    end else begin
      s_next.ms_div = s_reg.ms_div + 16'h0001;
    end

    // Peak records; first sample after reset always loads
    if (vout_meas_valid && (!s_reg.vout_seen[vout_meas_ch] || vout_meas > s_reg.vout_peak[vout_meas_ch])) begin
      s_next.vout_peak[vout_meas_ch] = vout_meas;
      s_next.vout_seen[vout_meas_ch] = 1'b1;
    end
    if (vin_meas_valid && (!s_reg.vin_seen || l11_fix(vin_meas) > l11_fix(s_reg.vin_peak))) begin
      s_next.vin_peak = vin_meas;
      s_next.vin_seen = 1'b1;
    end
    if (temp_meas_valid && (!s_reg.temp_seen || l11_fix(temp_meas) > l11_fix(s_reg.temp_peak))) begin
      s_next.temp_peak = temp_meas;
      s_next.temp_seen = 1'b1;
    end

    // Host writes
    // Each code touches its own field only
    if (do_write) begin
      unique case (cmd_code)
        8'hd5, 8'hd6, 8'hd7, 8'hd8: s_next.fault_resp[cmd_code[1:0] - 2'd1] = cmd_wdata[7:0];
        `PMCB_CMD_IEN_OV: s_next.ov_resp = cmd_wdata[7:0];
        `PMCB_CMD_IEN_UV: s_next.uv_resp = cmd_wdata[7:0];
        `PMCB_CMD_RETRY: s_next.retry = cmd_wdata;
        `PMCB_CMD_RESTART: s_next.restart = cmd_wdata;
        `PMCB_CMD_PG_DELAY: s_next.pg_delay = cmd_wdata;
        `PMCB_CMD_WD_FIRST: s_next.wd_first = cmd_wdata;
        `PMCB_CMD_WD_INT: s_next.wd_int = cmd_wdata;
        `PMCB_CMD_PAGE_MASK: s_next.page_mask = cmd_wdata[7:0];
        `PMCB_CMD_ADDR_BASE: s_next.addr_base = cmd_wdata[7:0];
        `PMCB_CMD_TRIM_DAC, `PMCB_CMD_DISCH_COEFF: begin
          if (page_ok) begin
            if (cmd_code == `PMCB_CMD_TRIM_DAC) begin
              s_next.dac[pch] = cmd_wdata[`PMCB_DAC_BITS-1:0];
            end else begin
              s_next.coeff[pch] = cmd_wdata;
            end
          end else if (page_global) begin
            // Unmasked channels keep their value
            for (int i = 0; i < 8; i++) begin
              if (s_reg.page_mask[i]) begin
                if (cmd_code == `PMCB_CMD_TRIM_DAC) begin
                  s_next.dac[i] = cmd_wdata[`PMCB_DAC_BITS-1:0];
                end else begin
                  s_next.coeff[i] = cmd_wdata;
                end
              end
            end
          end else begin
            // Pages 8 to 0xfe address nothing
            s_next.cml = 1'b1;
          end
        end
        // Read-only, send-only and foreign codes leave contents untouched
        default: s_next.cml = 1'b1;
      endcase
    end

    // Send byte
    // A pulse only; the log engine does the copy
    if (do_send) begin
      if (cmd_code == `PMCB_CMD_LOG_STORE) begin
        s_next.log_store = 1'b1;
        s_next.fault_off = 1'b1;
      end else begin
        s_next.cml = 1'b1;
      end
    end

    // Host reads
    // Refused reads still answer, with zero data
    if (do_read) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      unique case (cmd_code)
        8'hd5, 8'hd6, 8'hd7, 8'hd8: s_next.rdata = {8'h00, s_reg.fault_resp[cmd_code[1:0] - 2'd1]};
        `PMCB_CMD_IEN_OV: s_next.rdata = {8'h00, s_reg.ov_resp};
        `PMCB_CMD_IEN_UV: s_next.rdata = {8'h00, s_reg.uv_resp};
        `PMCB_CMD_RETRY: s_next.rdata = s_reg.retry;
        `PMCB_CMD_RESTART: s_next.rdata = s_reg.restart;
        `PMCB_CMD_VIN_PEAK: s_next.rdata = s_reg.vin_peak;
        `PMCB_CMD_TEMP_PEAK: s_next.rdata = s_reg.temp_peak;
        `PMCB_CMD_PG_DELAY: s_next.rdata = s_reg.pg_delay;
        `PMCB_CMD_WD_FIRST: s_next.rdata = s_reg.wd_first;
        `PMCB_CMD_WD_INT: s_next.rdata = s_reg.wd_int;
        `PMCB_CMD_PAGE_MASK: s_next.rdata = {8'h00, s_reg.page_mask};
        `PMCB_CMD_PADS: s_next.rdata = pad_in;
        `PMCB_CMD_ADDR_BASE: s_next.rdata = {8'h00, s_reg.addr_base};
        `PMCB_CMD_MAKER_ID: s_next.rdata = MAKER_ID;
        `PMCB_CMD_VOUT_PEAK, `PMCB_CMD_TRIM_DAC, `PMCB_CMD_LOT_CODE, `PMCB_CMD_DISCH_COEFF: begin
          // Paged reads need a single channel page
          if (!page_ok) begin
            s_next.cml = 1'b1;
          end else if (cmd_code == `PMCB_CMD_VOUT_PEAK) begin
            s_next.rdata = s_reg.vout_peak[pch];
          end else if (cmd_code == `PMCB_CMD_TRIM_DAC) begin
            s_next.rdata = {6'h00, s_reg.dac[pch]};
          end else if (cmd_code == `PMCB_CMD_LOT_CODE) begin
            s_next.rdata = {8'h00, nv_lot_code[pch]};
          end else begin
            s_next.rdata = s_reg.coeff[pch];
          end
        end
        default: s_next.cml = 1'b1;
      endcase
    end

    // Off thresholds, recomputed every cycle
    // Eight multipliers, traded for one cycle latency
    for (int i = 0; i < 8; i++) begin
      s_next.thr[i] = disch_thr(vout_command[i], s_reg.coeff[i]);
    end

    // Delayed internal control edge; release is immediate
    // Count stops at target; a shorter word acts at once
    if (!control_pin_active) begin
      s_next.restart_cnt = '0;
      s_next.ctrl_int = 1'b0;
    end else if (s_reg.restart_cnt >= l11_ms(s_reg.restart)) begin
      s_next.ctrl_int = 1'b1;
    end else if (s_reg.ms_tick) begin
      s_next.restart_cnt = s_reg.restart_cnt + 20'h00001;
    end

    // Delayed power good
    // Any drop of the raw input restarts the delay
    if (!power_good_raw) begin
      s_next.pg_cnt = '0;
      s_next.pg_out = 1'b0;
    end else if (s_reg.pg_cnt >= l11_ms(s_reg.pg_delay)) begin
      s_next.pg_out = 1'b1;
    end else if (s_reg.ms_tick) begin
      s_next.pg_cnt = s_reg.pg_cnt + 20'h00001;
    end

    // Retry pacing, one strobe per elapsed interval
    // Restarts on each strobe so intervals never drift
    if (!retry_active) begin
      s_next.retry_cnt = '0;
    end else if (s_reg.ms_tick) begin
      if (s_reg.retry_cnt + 20'h00001 >= l11_ms(s_reg.retry)) begin
        s_next.retry_cnt = '0;
        s_next.retry_pulse = 1'b1;
      end else begin
        s_next.retry_cnt = s_reg.retry_cnt + 20'h00001;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Zero fill clears peaks, counters and pulses
      s_reg <= '0;
      s_reg.fault_resp <= {4{`PMCB_RST_FAULT_RESP}};
      s_reg.ov_resp <= `PMCB_RST_IEN_RESP;
      s_reg.uv_resp <= `PMCB_RST_IEN_RESP;
      s_reg.retry <= `PMCB_RST_RETRY;
      s_reg.restart <= `PMCB_RST_RESTART;
      s_reg.pg_delay <= `PMCB_RST_PG_DELAY;
      s_reg.wd_first <= `PMCB_RST_WD;
      s_reg.wd_int <= `PMCB_RST_WD;
      s_reg.page_mask <= `PMCB_RST_PAGE_MASK;
      s_reg.addr_base <= `PMCB_RST_ADDR_BASE;
      s_reg.coeff <= {8{`PMCB_RST_DISCH_COEFF}};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  // All straight from the state register
  assign rd_data = s_reg.rdata;
  assign rd_valid = s_reg.rvalid;
  assign cml_fault = s_reg.cml;
  assign fault_log_store = s_reg.log_store;
  assign fault_off_event = s_reg.fault_off;
  assign fault_pin_response = s_reg.fault_resp;
  assign input_enable_ov_response = s_reg.ov_resp;
  assign input_enable_uv_response = s_reg.uv_resp;
  assign watchdog_first_interval = s_reg.wd_first;
  assign watchdog_interval = s_reg.wd_int;
  assign global_page_channel_mask = s_reg.page_mask;
  assign bus_address_base = s_reg.addr_base;
  assign trim_dac_code = s_reg.dac;
  assign discharge_threshold = s_reg.thr;
  assign control_internal_active = s_reg.ctrl_int;
  assign power_good_out = s_reg.pg_out;
  assign retry_strobe = s_reg.retry_pulse;

endmodule : pmcb_bank
`default_nettype wire

// file: test/pmcb_bank_checker.sv
/*
  Port checker of the manufacturer command bank.
  Assumes it is bound into every pmcb_bank instance.
*/
`timescale 1ns/100ps
`default_nettype none
module pmcb_bank_checker #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_send,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rd_valid,
  input wire logic cml_fault,
  input wire logic fault_log_store,
  input wire logic fault_off_event,
  input wire logic [7:0] global_page_channel_mask,
  input wire logic [7:0] bus_address_base,
  input wire logic [15:0] watchdog_interval,
  input wire logic control_pin_active,
  input wire logic control_internal_active,
  input wire logic power_good_raw,
  input wire logic power_good_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========
  // Command shapes
  sequence s_write(c);
    cmd_valid && !cmd_read && !cmd_send && cmd_code == c;
  endsequence
  sequence s_store;
    cmd_valid && cmd_send && !cmd_read && cmd_code == 8'hea;
  endsequence
  // ==========
  // Properties
  a_read_answer: assert property (cmd_valid && cmd_read |=> rd_valid)
    else $error("read not answered");
  a_idle_quiet: assert property (!cmd_valid |=> !rd_valid && !cml_fault && !fault_log_store)
    else $error("pulse without command");
  a_store_pulse: assert property (s_store |=> fault_log_store && !cml_fault && !rd_valid)
    else $error("store command not pulsed");
  a_fault_off_pair: assert property (fault_log_store |-> fault_off_event)
    else $error("store without fault off");
  a_ro_write_cml: assert property (s_write(8'hdd) or s_write(8'he7) |=> cml_fault)
    else $error("read only write not flagged");
  a_mask_write: assert property (s_write(8'he4) |=> global_page_channel_mask == $past(cmd_wdata[7:0]))
    else $error("mask not written");
  a_reset_default: assert property ($rose(nrst) |-> bus_address_base == 8'h5c && watchdog_interval == 16'h8000)
    else $error("defaults missing after reset");
  a_ctrl_cause: assert property (control_internal_active |-> $past(control_pin_active))
    else $error("control active without pin");
  a_pg_cause: assert property (power_good_out |-> $past(power_good_raw))
    else $error("power good without raw");
endmodule : pmcb_bank_checker

bind pmcb_bank pmcb_bank_checker #(.MS_CYCLES(MS_CYCLES)) chk_inst (
  .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_send(cmd_send),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .cml_fault(cml_fault),
  .fault_log_store(fault_log_store), .fault_off_event(fault_off_event),
  .global_page_channel_mask(global_page_channel_mask), .bus_address_base(bus_address_base),
  .watchdog_interval(watchdog_interval), .control_pin_active(control_pin_active),
  .control_internal_active(control_internal_active), .power_good_raw(power_good_raw),
  .power_good_out(power_good_out)
);
`default_nettype wire

// file: test/pmcb_host.sv
/*
  Host controller model issuing one decoded command per strobe.
  Assumes the bank answers exactly one cycle after the strobe edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pmcb_host (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic cml_fault,
  input wire logic fault_log_store,
  input wire logic fault_off_event,
  output logic cmd_valid,
  output logic cmd_read,
  output logic cmd_send,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic [7:0] page
);
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_send = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    page = 8'h00;
  end
  task automatic xfer(input logic rd, input logic snd, input logic [7:0] pg, input logic [7:0] code,
                      input logic [15:0] wd, output logic [15:0] q, output logic [2:0] st);
    @(negedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_send <= snd;
    cmd_code <= code;
    cmd_wdata <= wd;
    page <= pg;
    @(negedge clk);
    q = rd_data;
    st = {rd_valid, fault_log_store && fault_off_event, cml_fault};
    cmd_valid <= 1'b0;
    // Idle code and data lines carry inverted values so stale data cannot pass
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
  endtask : xfer
endmodule : pmcb_host
`default_nettype wire

// file: test/pmcb_bank_tb.sv
/*
  Self-checking bench of the command bank.
  Assumes the checker is bound and the host model drives commands.
*/
`timescale 1ns/100ps
`default_nettype none
module pmcb_bank_tb;
  localparam logic [15:0] ID = 16'h2b6d; // Arbitrary value
  logic clk, nrst, cmd_valid, cmd_read, cmd_send, vout_meas_valid, vin_meas_valid, temp_meas_valid;
  logic control_pin_active, power_good_raw, retry_active, rd_valid, cml_fault, fault_log_store;
  logic fault_off_event, control_internal_active, power_good_out, retry_strobe;
  logic [7:0] cmd_code, page, ov_r, uv_r, mask, addr;
  logic [15:0] cmd_wdata, vout_meas, vin_meas, temp_meas, pad_in, rd_data, wdf, wdi, q;
  logic [2:0] vout_meas_ch, st;
  logic [3:0][7:0] fault_pin_response;
  logic [7:0][7:0] nv_lot_code;
  logic [7:0][15:0] vout_command, discharge_threshold;
  logic [7:0][9:0] trim_dac_code;
  int errors, tests_run, n;
  logic [7:0] codes [15] = '{8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'he0, 8'he1, 8'he2,
                             8'he3, 8'he4, 8'he6, 8'he9};
  logic [15:0] dflt [15] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hf320, 16'hfb20, 16'h0, 16'heb20,
                             16'h8000, 16'h8000, 16'h00ff, 16'h005c, 16'hc200};
  logic [15:0] wmask [15] = '{16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hff, 16'hffff, 16'hffff, 16'h3ff,
                              16'hffff, 16'hffff, 16'hffff, 16'hff, 16'hff, 16'hffff};

  pmcb_bank #(.MS_CYCLES(4), .MAKER_ID(ID)) pmcb_bank_inst (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_send(cmd_send),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .page(page), .vout_meas_valid(vout_meas_valid),
    .vout_meas_ch(vout_meas_ch), .vout_meas(vout_meas), .vin_meas_valid(vin_meas_valid), .vin_meas(vin_meas),
    .temp_meas_valid(temp_meas_valid), .temp_meas(temp_meas), .pad_in(pad_in), .nv_lot_code(nv_lot_code),
    .vout_command(vout_command), .control_pin_active(control_pin_active), .power_good_raw(power_good_raw),
    .retry_active(retry_active), .rd_data(rd_data), .rd_valid(rd_valid), .cml_fault(cml_fault),
    .fault_log_store(fault_log_store), .fault_off_event(fault_off_event), .fault_pin_response(fault_pin_response),
    .input_enable_ov_response(ov_r), .input_enable_uv_response(uv_r), .watchdog_first_interval(wdf),
    .watchdog_interval(wdi), .global_page_channel_mask(mask), .bus_address_base(addr),
    .trim_dac_code(trim_dac_code), .discharge_threshold(discharge_threshold),
    .control_internal_active(control_internal_active), .power_good_out(power_good_out),
    .retry_strobe(retry_strobe)
  );
  pmcb_host pmcb_host_inst (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cml_fault(cml_fault),
    .fault_log_store(fault_log_store), .fault_off_event(fault_off_event), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_send(cmd_send), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .page(page)
  );

  // ==========
  // Helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic xf(input logic r, input logic s, input logic [7:0] pg, input logic [7:0] c, input logic [15:0] d);
    pmcb_host_inst.xfer(r, s, pg, c, d, q, st);
  endtask : xf
  task automatic meas(input int k, input logic [15:0] a, input logic [15:0] b);
    for (int j = 0; j < 2; j++) begin
      @(negedge clk);
      vin_meas_valid = (k == 0);
      temp_meas_valid = (k == 1);
      vout_meas_valid = (k == 2);
      vin_meas = j ? b : a;
      temp_meas = j ? b : a;
      vout_meas = j ? b : a;
    end
    @(negedge clk);
    {vin_meas_valid, temp_meas_valid, vout_meas_valid} = 3'b000;
  endtask : meas
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end

  // ==========
  // Main sequence
  initial begin
    {nrst, vout_meas_valid, vin_meas_valid, temp_meas_valid} = 4'h0;
    {control_pin_active, power_good_raw, retry_active} = 3'b000;
    {vout_meas, vin_meas, temp_meas, vout_meas_ch} = {48'h0, 3'd3};
    pad_in = 16'h1234;
    for (int i = 0; i < 8; i++) begin
      nv_lot_code[i] = 8'h30 + 8'(i);
      vout_command[i] = 16'h2000;
    end
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 15; i++) begin
      xf(1'b1, 1'b0, 8'h00, codes[i], 16'h0);
      chk("default", q, dflt[i]);
    end
    $display("test defaults done");
    for (int i = 0; i < 15; i++) begin
      xf(1'b0, 1'b0, 8'h00, codes[i], 16'h5ac3 ^ {8'h00, codes[i]});
      xf(1'b1, 1'b0, 8'h00, codes[i], 16'h0);
      chk("readback", q, (16'h5ac3 ^ {8'h00, codes[i]}) & wmask[i]);
    end
    chk("pin0 resp", {8'h0, fault_pin_response[0]}, 16'h0016);
    chk("wd port", wdi, 16'h5a20);
    chk("addr port", {8'h0, addr}, 16'h0025);
    chk("dac port", {6'h0, trim_dac_code[0]}, 16'h0223);
    chk("pin3 resp", {8'h0, fault_pin_response[3]}, 16'h001b);
    chk("ov port", {8'h0, ov_r}, 16'h001a);
    chk("uv port", {8'h0, uv_r}, 16'h0019);
    chk("wd first port", wdf, 16'h5a21);
    $display("test readback done");
    xf(1'b0, 1'b0, 8'h03, 8'hdd, 16'h1111);
    chk("ro write", {13'h0, st}, 16'h0001);
    xf(1'b0, 1'b0, 8'h00, 8'he7, 16'h1111);
    chk("id write", {13'h0, st}, 16'h0001);
    xf(1'b1, 1'b0, 8'h00, 8'he7, 16'h0);
    chk("id", q, ID);
    xf(1'b1, 1'b0, 8'h03, 8'hdd, 16'h0);
    chk("peak kept", q, 16'h0000);
    xf(1'b1, 1'b0, 8'h09, 8'he0, 16'h0);
    chk("bad page read", {q[12:0], st}, 16'h0005);
    xf(1'b0, 1'b1, 8'h00, 8'hd5, 16'h0);
    chk("bad send", {13'h0, st}, 16'h0001);
    xf(1'b0, 1'b1, 8'h00, 8'hea, 16'h0);
    chk("store", {13'h0, st}, 16'h0002);
    $display("test refusals done");
    meas(0, 16'hd280, 16'hf808);
    meas(1, 16'h0019, 16'h001a);
    meas(2, 16'h9800, 16'h8000);
    xf(1'b1, 1'b0, 8'h00, 8'hde, 16'h0);
    chk("vin peak", q, 16'hd280);
    xf(1'b1, 1'b0, 8'h00, 8'hdf, 16'h0);
    chk("temp peak", q, 16'h001a);
    xf(1'b1, 1'b0, 8'h03, 8'hdd, 16'h0);
    chk("vout peak", q, 16'h9800);
    @(negedge clk);
    pad_in = 16'hbeef;
    xf(1'b1, 1'b0, 8'h00, 8'he5, 16'h0);
    chk("pads", q, 16'hbeef);
    xf(1'b1, 1'b0, 8'h05, 8'he8, 16'h0);
    chk("lot", q, 16'h0035);
    $display("test telemetry done");
    xf(1'b0, 1'b0, 8'h02, 8'he9, 16'hf801);
    repeat (2) @(negedge clk);
    chk("thr half", discharge_threshold[2], 16'h1000);
    chk("thr two", discharge_threshold[1], 16'h4000);
    xf(1'b0, 1'b0, 8'h00, 8'he4, 16'h0005);
    xf(1'b0, 1'b0, 8'hff, 8'he0, 16'h0155);
    chk("dac ch0", {6'h0, trim_dac_code[0]}, 16'h0155);
    chk("dac ch1", {6'h0, trim_dac_code[1]}, 16'h0000);
    chk("dac ch2", {6'h0, trim_dac_code[2]}, 16'h0155);
    $display("test threshold and global page done");
    xf(1'b0, 1'b0, 8'h00, 8'he1, 16'h0002);
    xf(1'b0, 1'b0, 8'h00, 8'hdc, 16'h0000);
    xf(1'b0, 1'b0, 8'h00, 8'hdb, 16'h0001);
    @(negedge clk);
    {power_good_raw, control_pin_active} = 2'b11;
    for (n = 0; power_good_out !== 1'b1 && n < 40; n++) begin
      @(negedge clk);
      if (n == 1)
        chk("ctrl zero delay", {15'h0, control_internal_active}, 16'h0001);
    end
    chk("pg delay", {15'h0, n >= 4 && n <= 12}, 16'h0001);
    control_pin_active = 1'b0;
    retry_active = 1'b1;
    repeat (2) @(negedge clk);
    chk("ctrl off", {15'h0, control_internal_active}, 16'h0000);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += int'(retry_strobe === 1'b1);
    end
    chk("retry count", {15'h0, n >= 9 && n <= 11}, 16'h0001);
    $display("test delays done");
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    xf(1'b1, 1'b0, 8'h00, 8'he6, 16'h0);
    chk("addr after reset", q, 16'h005c);
    xf(1'b1, 1'b0, 8'h03, 8'hdd, 16'h0);
    chk("peak after reset", q, 16'h0000);
    $display("test second reset done");
    complete_run();
  end
endmodule : pmcb_bank_tb
`default_nettype wire
